// file: core/pbc_pkg.sv
// pbc_pkg: constants and types shared by the port b / port c pin multiplexer
package pbc_pkg;
   // interface_config low field: owner of port b bits 3..7 when alt select bit is 0
   localparam logic [1:0] PBC_IF_PORTS = 2'h0;
   localparam logic [1:0] PBC_IF_CPU_BUS = 2'h1;
   localparam logic [1:0] PBC_IF_WAVE = 2'h2;
   localparam logic [1:0] PBC_IF_FIFO = 2'h3;
   // pin bit positions inside the eight pin vector
   localparam int PBC_B3 = 0;
   localparam int PBC_B4 = 1;
   localparam int PBC_B5 = 2;
   localparam int PBC_B6 = 3;
   localparam int PBC_B7 = 4;
   localparam int PBC_C0 = 5;
   localparam int PBC_C1 = 6;
   localparam int PBC_C2 = 7;
   localparam int PBC_PINS = 8;
   // values after reset
   localparam logic [7:0] PBC_PIN_OUT_RST = 8'h00;
   localparam logic [7:0] PBC_PIN_OE_RST = 8'h00;
   localparam logic [7:0] PBC_PIN_SYNC_RST = 8'hFF;
   localparam logic [4:0] PBC_BUS_RST = 5'h00;
   // owner encoding of each pin
   typedef enum logic [4:0] {
      PBC_OWN_GPIO = 5'b0_0001,
      PBC_OWN_ALT = 5'b0_0010,
      PBC_OWN_CPU = 5'b0_0100,
      PBC_OWN_WAVE = 5'b0_1000,
      PBC_OWN_FIFO = 5'b1_0000
   } pbc_owner_t;
endpackage : pbc_pkg

// file: core/pbc_edge_detect.sv
// pbc_edge_detect: rising and falling edge pulses of one registered pin level
module pbc_edge_detect (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   // sampled pin level
   input wire logic level_in,
   // edge pulses
   output logic rise_out,
   output logic fall_out
);
   import pbc_pkg::*;

   typedef struct packed {
      logic prev;
      logic rise;
      logic fall;
   } pbc_edge_state_t;

   pbc_edge_state_t st_reg;
   pbc_edge_state_t st_next;

   always_comb begin
      st_next = st_reg;
      st_next.prev = level_in;
      st_next.rise = level_in & ~st_reg.prev;
      st_next.fall = ~level_in & st_reg.prev;
   end

   // idle high matches the reset value of the pin sampler, so no false edge
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_reg <= '{prev: 1'b1, rise: 1'b0, fall: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign rise_out = st_reg.rise;
   assign fall_out = st_reg.fall;
endmodule : pbc_edge_detect

// file: core/pbc_pin_mux.sv
// pbc_pin_mux: owner selection for port b bits 3..7 and port c bits 0..2
// Overview of operation
// - port b owner from alt bit and config
// - port c 0/1 from alt and wave select
// - port c bit two: gpio or irq0 only
// - serial transmit: clock sync, data async
// - serial0 receive from pin when c0 alt owned
// - irq four and six on rising edge
// - irq five active low, falling edge
// - timer2 overflow pin high one cycle
// - irq0 active low, edge or level
// - wave engine takes port c ready inputs
// - port b carries cpu, wave or fifo bus
module pbc_pin_mux (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   // selection bits from the processor
   input wire logic [7:3] port_b_alt_select_in,
   input wire logic [2:0] port_c_alt_select_in,
   input wire logic [1:0] port_c_wave_select_in,
   input wire logic [1:0] interface_config_in,
   input wire logic irq0_trigger_type_in,
   // pin pad signals, index by pbc_pkg pin positions
   input wire logic [pbc_pkg::PBC_PINS-1:0] pin_in,
   output logic [pbc_pkg::PBC_PINS-1:0] pin_out,
   output logic [pbc_pkg::PBC_PINS-1:0] pin_oe_out,
   // general purpose port bits
   input wire logic [pbc_pkg::PBC_PINS-1:0] gpio_data_in,
   input wire logic [pbc_pkg::PBC_PINS-1:0] gpio_dir_in,
   output logic [pbc_pkg::PBC_PINS-1:0] gpio_read_out,
   // serial ports
   input wire logic serial0_sync_mode_in,
   input wire logic serial0_shift_clk_in,
   input wire logic serial0_tx_data_in,
   input wire logic serial1_sync_mode_in,
   input wire logic serial1_shift_clk_in,
   input wire logic serial1_tx_data_in,
   output logic serial0_receive_out,
   // interrupt requests
   output logic ext_irq_four_out,
   output logic ext_irq_five_out,
   output logic ext_irq_six_out,
   output logic ext_irq_zero_out,
   // timer 2
   input wire logic timer2_overflow_in,
   // shared bus bits 3..7 (processor, waveform engine, fifo a)
   input wire logic [7:3] cpu_bus_data_in,
   input wire logic cpu_bus_oe_in,
   input wire logic [7:3] wave_data_bus_a_in,
   input wire logic wave_data_oe_in,
   input wire logic [7:3] fifo_a_data_bus_in,
   input wire logic fifo_a_data_oe_in,
   output logic [7:3] cpu_bus_read_out,
   output logic [7:3] wave_data_bus_a_out,
   output logic [7:3] fifo_a_data_bus_out,
   // waveform engine ready inputs
   output logic wave_ready_in_zero_out,
   output logic wave_ready_in_one_out
);
   import pbc_pkg::*;

   // latency from a pin change: one sampling flop, then one stage more for
   // the gpio, bus, receive and ready reads; edge requests add the detector,
   // three cycles in all, while the level request of irq0 takes two.
   // drive side: owner and value are registered once, one cycle behind the
   // inputs; the price of flop outputs on every pad.

   typedef struct packed {
      logic [PBC_PINS-1:0] sync;
      logic [PBC_PINS-1:0] out;
      logic [PBC_PINS-1:0] oe;
      logic [PBC_PINS-1:0] gpio_rd;
      logic [4:0] cpu_rd;
      logic [4:0] wave_rd;
      logic [4:0] fifo_rd;
      logic rx0;
      logic wave_ready_in_zero;
      logic wave_ready_in_one;
      logic irq4;
      logic irq5;
      logic irq6;
      logic irq0;
   } pbc_state_t;

   pbc_state_t st_reg;
   pbc_state_t st_next;
   pbc_owner_t owner [PBC_PINS];
   logic [PBC_PINS-1:0] alt_out;
   logic [PBC_PINS-1:0] alt_is_out;
   // padded to the pin vector so the per pin loop never indexes past the bus
   logic [PBC_PINS-1:0] bus_out;
   logic [PBC_PINS-1:0] bus_oe;
   logic rise_b4;
   logic fall_b5;
   logic rise_b6;
   logic fall_c2;

   ////////////////////////////////////////////////////////////////////////////
   // owner of each pin

   always_comb begin
      pbc_owner_t b_default;
      b_default = PBC_OWN_GPIO;
      unique case (interface_config_in)
         PBC_IF_PORTS: b_default = PBC_OWN_GPIO;
         PBC_IF_CPU_BUS: b_default = PBC_OWN_CPU;
         PBC_IF_WAVE: b_default = PBC_OWN_WAVE;
         PBC_IF_FIFO: b_default = PBC_OWN_FIFO;
      endcase
      // a port b pin with its alt bit clear follows the interface field
      for (int i = 0; i < 5; i++) begin
         owner[i] = port_b_alt_select_in[i+3] ? PBC_OWN_ALT : b_default;
      end
      // port c 0/1 owner, wave select wins over alt
      for (int i = 0; i < 2; i++) begin
         if (port_c_wave_select_in[i]) begin
            owner[PBC_C0+i] = PBC_OWN_WAVE;
         end else if (port_c_alt_select_in[i]) begin
            owner[PBC_C0+i] = PBC_OWN_ALT;
         end else begin
            owner[PBC_C0+i] = PBC_OWN_GPIO;
         end
      end
      owner[PBC_C2] = port_c_alt_select_in[2] ? PBC_OWN_ALT : PBC_OWN_GPIO;
   end

   ////////////////////////////////////////////////////////////////////////////
   // alternate function drive values

   always_comb begin
      alt_out = '0;
      alt_is_out = '0;
      // alt owned input pins (irq, receive) keep their drivers off
      // serial1 transmit on port b bit three
      alt_out[PBC_B3] = serial1_sync_mode_in ? serial1_shift_clk_in : serial1_tx_data_in;
      alt_is_out[PBC_B3] = 1'b1;
      // overflow pulse, one cycle per event
      alt_out[PBC_B7] = timer2_overflow_in;
      alt_is_out[PBC_B7] = 1'b1;
      // serial0 transmit on port c bit one
      alt_out[PBC_C1] = serial0_sync_mode_in ? serial0_shift_clk_in : serial0_tx_data_in;
      alt_is_out[PBC_C1] = 1'b1;
   end

   // one shared enable per bus owner; all five bus bits turn together
   always_comb begin
      bus_out = {3'b000, cpu_bus_data_in};
      bus_oe = '0;
      if (interface_config_in == PBC_IF_CPU_BUS) begin
         bus_out = {3'b000, cpu_bus_data_in};
         bus_oe = {3'b000, {5{cpu_bus_oe_in}}};
      end else if (interface_config_in == PBC_IF_WAVE) begin
         bus_out = {3'b000, wave_data_bus_a_in};
         bus_oe = {3'b000, {5{wave_data_oe_in}}};
      end else if (interface_config_in == PBC_IF_FIFO) begin
         bus_out = {3'b000, fifo_a_data_bus_in};
         bus_oe = {3'b000, {5{fifo_a_data_oe_in}}};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // edge detectors on sampled pins
   // pins are synchronous, so the single sampling flop feeds the detectors

   pbc_edge_detect u_edge_b4 (
      .ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in),
      .level_in(st_reg.sync[PBC_B4]),
      .rise_out(rise_b4),
      .fall_out()
   );

   pbc_edge_detect u_edge_b5 (
      .ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in),
      .level_in(st_reg.sync[PBC_B5]),
      .rise_out(),
      .fall_out(fall_b5)
   );

   pbc_edge_detect u_edge_b6 (
      .ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in),
      .level_in(st_reg.sync[PBC_B6]),
      .rise_out(rise_b6),
      .fall_out()
   );

   // falling edge for irq0 edge mode
   pbc_edge_detect u_edge_c2 (
      .ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in),
      .level_in(st_reg.sync[PBC_C2]),
      .rise_out(),
      .fall_out(fall_c2)
   );

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      st_next = st_reg;
      st_next.sync = pin_in;
      st_next.gpio_rd = st_reg.sync;
      for (int i = 0; i < PBC_PINS; i++) begin
         st_next.out[i] = 1'b0;
         st_next.oe[i] = 1'b0;
         unique case (owner[i])
            PBC_OWN_GPIO: begin
               st_next.out[i] = gpio_data_in[i];
               st_next.oe[i] = gpio_dir_in[i];
            end
            PBC_OWN_ALT: begin
               st_next.out[i] = alt_out[i];
               st_next.oe[i] = alt_is_out[i];
            end
            PBC_OWN_CPU, PBC_OWN_WAVE, PBC_OWN_FIFO: begin
               // port c pins carry no bus bit; wave owned c0/c1 are inputs only
               if (i < 5) begin
                  st_next.out[i] = bus_out[i];
                  st_next.oe[i] = bus_oe[i];
               end
            end
         endcase
      end
      // bus read data only to the owning engine
      st_next.cpu_rd = PBC_BUS_RST;
      st_next.wave_rd = PBC_BUS_RST;
      st_next.fifo_rd = PBC_BUS_RST;
      unique case (interface_config_in)
         PBC_IF_PORTS: ;
         PBC_IF_CPU_BUS: st_next.cpu_rd = st_reg.sync[4:0];
         PBC_IF_WAVE: st_next.wave_rd = st_reg.sync[4:0];
         PBC_IF_FIFO: st_next.fifo_rd = st_reg.sync[4:0];
      endcase
      // receive data only when c0 is alt owned; idle high when not owned
      // idle high looks like a quiet line, so no false start bit
      st_next.rx0 = (owner[PBC_C0] == PBC_OWN_ALT) ? st_reg.sync[PBC_C0] : 1'b1;
      // ready inputs to the waveform engine
      st_next.wave_ready_in_zero = (owner[PBC_C0] == PBC_OWN_WAVE) & st_reg.sync[PBC_C0];
      st_next.wave_ready_in_one = (owner[PBC_C1] == PBC_OWN_WAVE) & st_reg.sync[PBC_C1];
      st_next.irq4 = (owner[PBC_B4] == PBC_OWN_ALT) & rise_b4;
      st_next.irq6 = (owner[PBC_B6] == PBC_OWN_ALT) & rise_b6;
      st_next.irq5 = (owner[PBC_B5] == PBC_OWN_ALT) & fall_b5;
      // edge pulse or low level
      // level mode has no memory: the request drops two cycles after the pin rises
      st_next.irq0 = (owner[PBC_C2] == PBC_OWN_ALT) &
                     (irq0_trigger_type_in ? fall_c2 : ~st_reg.sync[PBC_C2]);
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   // fields spelled out so the pin vector and bus reset values are package constants
   // all pins gpio inputs after reset
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_reg.sync <= PBC_PIN_SYNC_RST;
         st_reg.out <= PBC_PIN_OUT_RST;
         st_reg.oe <= PBC_PIN_OE_RST;
         st_reg.gpio_rd <= PBC_PIN_SYNC_RST;
         st_reg.cpu_rd <= PBC_BUS_RST;
         st_reg.wave_rd <= PBC_BUS_RST;
         st_reg.fifo_rd <= PBC_BUS_RST;
         st_reg.rx0 <= 1'b1;
         st_reg.wave_ready_in_zero <= 1'b0;
         st_reg.wave_ready_in_one <= 1'b0;
         st_reg.irq4 <= 1'b0;
         st_reg.irq5 <= 1'b0;
         st_reg.irq6 <= 1'b0;
         st_reg.irq0 <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, all straight from flip-flops

   assign pin_out = st_reg.out;
   assign pin_oe_out = st_reg.oe;
   assign gpio_read_out = st_reg.gpio_rd;
   assign serial0_receive_out = st_reg.rx0;
   assign ext_irq_four_out = st_reg.irq4;
   assign ext_irq_five_out = st_reg.irq5;
   assign ext_irq_six_out = st_reg.irq6;
   assign ext_irq_zero_out = st_reg.irq0;
   assign cpu_bus_read_out = st_reg.cpu_rd;
   assign wave_data_bus_a_out = st_reg.wave_rd;
   assign fifo_a_data_bus_out = st_reg.fifo_rd;
   assign wave_ready_in_zero_out = st_reg.wave_ready_in_zero;
   assign wave_ready_in_one_out = st_reg.wave_ready_in_one;
endmodule : pbc_pin_mux

// file: dv/pbc_pin_mux_assertions.sv
// pbc_pin_mux_assertions: port level checks of the pin multiplexer
module pbc_pin_mux_assertions (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   // selection
   input wire logic [7:3] port_b_alt_select_in,
   input wire logic [2:0] port_c_alt_select_in,
   input wire logic [1:0] port_c_wave_select_in,
   input wire logic [1:0] interface_config_in,
   input wire logic irq0_trigger_type_in,
   // pads
   input wire logic [7:0] pin_in,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe_out,
   input wire logic [7:0] gpio_dir_in,
   // engine side
   input wire logic serial1_sync_mode_in,
   input wire logic serial1_shift_clk_in,
   input wire logic serial1_tx_data_in,
   input wire logic timer2_overflow_in,
   input wire logic [7:3] fifo_a_data_bus_in,
   input wire logic fifo_a_data_oe_in,
   input wire logic ext_irq_four_out,
   input wire logic ext_irq_five_out,
   input wire logic ext_irq_zero_out,
   input wire logic wave_ready_in_zero_out
);
   timeunit 1ns;
   timeprecision 100ps;
   import pbc_pkg::*;
   default clocking @(posedge ref_clk_in);
   endclocking
   default disable iff (!resetn_in);
   wire tx1 = serial1_sync_mode_in ? serial1_shift_clk_in : serial1_tx_data_in;
   ////////////////////////////////
   chk_b3_serial_tx: assert property (port_b_alt_select_in[3]
      |=> pin_oe_out[0] && pin_out[0] == $past(tx1)) else $error("b3 transmit wrong");
   chk_b7_timer_out: assert property (port_b_alt_select_in[7]
      |=> pin_oe_out[4] && pin_out[4] == $past(timer2_overflow_in)) else $error("timer pin wrong");
   // alt held from before the edge so selection latency cannot hide it
   chk_irq4_rise_edge: assert property (($past(port_b_alt_select_in[4]) && $rose(pin_in[1]))
      ##0 port_b_alt_select_in[4] [*3] |=> ext_irq_four_out) else $error("irq4 missed");
   chk_irq5_fall_edge: assert property (($past(port_b_alt_select_in[5]) && $fell(pin_in[2]))
      ##0 port_b_alt_select_in[5] [*3] |=> ext_irq_five_out) else $error("irq5 missed");
   chk_irq0_low_level: assert property ((port_c_alt_select_in[2] && !irq0_trigger_type_in && !pin_in[7])
      [*3] |-> ext_irq_zero_out) else $error("irq0 level missed");
   chk_c2_gpio_dir: assert property (!port_c_alt_select_in[2]
      |=> pin_oe_out[7] == $past(gpio_dir_in[7])) else $error("c2 direction wrong");
   chk_c0_wave_ready: assert property (port_c_wave_select_in[0] [*3]
      |-> wave_ready_in_zero_out == $past(pin_in[5], 2) && !pin_oe_out[5]) else $error("ready0 wrong");
   chk_fifo_bus_drive: assert property (port_b_alt_select_in == 5'h00 && interface_config_in == PBC_IF_FIFO
      && fifo_a_data_oe_in |=> pin_oe_out[4:0] == 5'h1F && pin_out[4:0] == $past(fifo_a_data_bus_in))
      else $error("fifo bus drive wrong");
   chk_reset_inputs: assert property ($rose(resetn_in) |-> pin_oe_out == 8'h00)
      else $error("pins driven after reset");
   cover property (ext_irq_four_out);
   cover property (ext_irq_zero_out);
   cover property (pin_out[4] && pin_oe_out[4]);
endmodule : pbc_pin_mux_assertions

bind pbc_pin_mux pbc_pin_mux_assertions pbc_pin_mux_assertions_inst (.*);

// file: dv/pbc_pad_model.sv
// pbc_pad_model: external parts sharing the port pins
module pbc_pad_model (
   // design pad side
   input wire logic [7:0] pad_drive_in,
   input wire logic [7:0] pad_oe_in,
   // level the external part drives
   input wire logic [7:0] ext_level_in,
   output logic [7:0] pad_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // device drive wins, else the part
   assign pad_out = (pad_oe_in & pad_drive_in) | (~pad_oe_in & ext_level_in);
endmodule : pbc_pad_model

// file: dv/pbc_pin_mux_test.sv
// pbc_pin_mux_test: directed bench for the pin multiplexer
module pbc_pin_mux_test;
   timeunit 1ns;
   timeprecision 100ps;
   import pbc_pkg::*;
   logic ref_clk_in = 1'b0, resetn_in = 1'b0, irq0_trigger_type_in = 1'b0;
   logic [7:3] port_b_alt_select_in = 5'h00;
   logic [2:0] port_c_alt_select_in = 3'h0;
   logic [1:0] port_c_wave_select_in = 2'h0, interface_config_in = 2'h0;
   logic [7:0] gpio_data_in = 8'h5A, gpio_dir_in = 8'h00, ext = 8'hF5;
   logic [7:0] pin_in, pin_out, pin_oe_out, gpio_read_out;
   logic serial0_sync_mode_in = 1'b0, serial0_shift_clk_in = 1'b1, serial0_tx_data_in = 1'b0;
   logic serial1_sync_mode_in = 1'b0, serial1_shift_clk_in = 1'b1, serial1_tx_data_in = 1'b0;
   logic timer2_overflow_in = 1'b0, cpu_bus_oe_in = 1'b0, wave_data_oe_in = 1'b0, fifo_a_data_oe_in = 1'b0;
   logic [7:3] cpu_bus_data_in = 5'h11, wave_data_bus_a_in = 5'h0A, fifo_a_data_bus_in = 5'h15;
   logic [7:3] cpu_bus_read_out, wave_data_bus_a_out, fifo_a_data_bus_out;
   logic serial0_receive_out, ext_irq_four_out, ext_irq_five_out, ext_irq_six_out, ext_irq_zero_out;
   logic wave_ready_in_zero_out, wave_ready_in_one_out;
   logic [4:0] bus_tbl [4] = '{5'h00, 5'h11, 5'h0A, 5'h15};
   int n_mismatch = 0, samples_checked = 0;
   int cnt [5];
   pbc_pin_mux pbc_pin_mux_inst (.*);
   pbc_pad_model pbc_pad_model_inst (.pad_drive_in(pin_out), .pad_oe_in(pin_oe_out), .ext_level_in(ext),
      .pad_out(pin_in));
   initial forever #2.5 ref_clk_in = ~ref_clk_in;
   // pulse counters: catch one-cycle outputs without racing the edge
   always @(posedge ref_clk_in) begin
      cnt[0] += int'(ext_irq_four_out === 1'b1);
      cnt[1] += int'(ext_irq_five_out === 1'b1);
      cnt[2] += int'(ext_irq_six_out === 1'b1);
      cnt[3] += int'(ext_irq_zero_out === 1'b1);
      cnt[4] += int'((pin_out[4] & pin_oe_out[4]) === 1'b1);
   end
   ////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_in);
   endtask : tick
   // sample at the falling edge, well clear of updates
   task automatic look(input int n);
      tick(n);
      @(negedge ref_clk_in);
   endtask : look
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (20000) @(posedge ref_clk_in);
      n_mismatch++;
      report_and_stop();
   end
   ////////////////////////////////
   initial begin
      tick(8);
      resetn_in <= 1'b1;
      look(3);
      chk("oe", pin_oe_out, 8'h00);
      chk("read", gpio_read_out, 8'hF5);
      tick(1);
      gpio_dir_in <= 8'hFF;
      look(3);
      chk("gpio out", pin_out & pin_oe_out, 8'h5A);
      chk("gpio read", gpio_read_out, 8'h5A);
      $display("test reset and gpio done");
      for (int i = 0; i < 4; i++) begin
         tick(1);
         gpio_dir_in <= 8'h00;
         port_b_alt_select_in <= 5'h01;
         port_c_alt_select_in <= 3'h2;
         {serial0_sync_mode_in, serial1_sync_mode_in} <= {2{i[1]}};
         {serial0_shift_clk_in, serial1_shift_clk_in} <= {2{i[0]}};
         {serial0_tx_data_in, serial1_tx_data_in} <= {2{~i[0]}};
         look(2);
         chk("tx", {4'h0, pin_oe_out[6], pin_oe_out[0], pin_out[6], pin_out[0]}, {6'h03, {2{i[1] ~^ i[0]}}});
      end
      $display("test serial done");
      tick(1);
      port_b_alt_select_in <= 5'h00;
      port_c_alt_select_in <= 3'h0;
      for (int c = 0; c < 4; c++) begin
         interface_config_in <= 2'(c);
         {cpu_bus_oe_in, wave_data_oe_in, fifo_a_data_oe_in} <= 3'h7;
         look(2);
         chk("bus oe", {3'h0, pin_oe_out[4:0]}, (c == 0) ? 8'h00 : 8'h1F);
         chk("bus out", {3'h0, pin_out[4:0] & pin_oe_out[4:0]}, {3'h0, bus_tbl[c]});
         tick(1);
         {cpu_bus_oe_in, wave_data_oe_in, fifo_a_data_oe_in} <= 3'h0;
         ext <= 8'hF9;
         look(3);
         chk("cpu rd", {3'h0, cpu_bus_read_out}, (c == 1) ? 8'h19 : 8'h00);
         chk("wave rd", {3'h0, wave_data_bus_a_out}, (c == 2) ? 8'h19 : 8'h00);
         chk("fifo rd", {3'h0, fifo_a_data_bus_out}, (c == 3) ? 8'h19 : 8'h00);
         tick(1);
         ext <= 8'hF5;
      end
      $display("test bus owners done");
      port_b_alt_select_in <= 5'h0E;
      look(3);
      for (int k = 0; k < 2; k++) begin
         cnt = '{default: 0};
         tick(1);
         ext <= k ? 8'hF5 : 8'hFB;
         look(6);
         for (int j = 0; j < 3; j++) chk("irq", 8'(cnt[j]), 8'(1 - k));
      end
      tick(1);
      port_b_alt_select_in <= 5'h10;
      look(2);
      cnt = '{default: 0};
      tick(1);
      timer2_overflow_in <= 1'b1;
      tick(1);
      timer2_overflow_in <= 1'b0;
      look(3);
      chk("t2 pulse", 8'(cnt[4]), 8'h01);
      $display("test irq and timer done");
      tick(1);
      port_c_alt_select_in <= 3'h4;
      irq0_trigger_type_in <= 1'b1;
      look(3);
      cnt = '{default: 0};
      tick(1);
      ext <= 8'h75;
      look(5);
      chk("irq0 edge", 8'(cnt[3]), 8'h01);
      tick(1);
      ext <= 8'hF5;
      look(3);
      tick(1);
      irq0_trigger_type_in <= 1'b0;
      look(2);
      cnt = '{default: 0};
      tick(1);
      ext <= 8'h75;
      tick(5);
      ext <= 8'hF5;
      look(4);
      chk("irq0 level", 8'(cnt[3]), 8'h05);
      cnt = '{default: 0};
      tick(1);
      port_c_alt_select_in <= 3'h0;
      gpio_dir_in <= 8'h80;
      look(5);
      // b7 still carries the timer output
      chk("c2 oe", pin_oe_out, 8'h90);
      chk("irq0 off", 8'(cnt[3]), 8'h00);
      $display("test irq0 done");
      for (int v = 0; v < 2; v++) begin
         tick(1);
         port_c_wave_select_in <= 2'h3;
         port_c_alt_select_in <= 3'h3;
         gpio_dir_in <= 8'h00;
         ext <= v ? 8'hF5 : 8'h95;
         look(3);
         chk("rdy", {4'h0, wave_ready_in_one_out, wave_ready_in_zero_out, pin_oe_out[6:5]}, 8'(v * 12));
         chk("rx0 wave", {7'h00, serial0_receive_out}, 8'h01);
         tick(1);
         port_c_wave_select_in <= 2'h0;
         look(3);
         chk("rx0", {7'h00, serial0_receive_out}, 8'(v));
         chk("c1 tx", {7'h00, pin_oe_out[6]}, 8'h01);
      end
      $display("test port c done");
      report_and_stop();
   end
endmodule : pbc_pin_mux_test
